//--- adcc_consts.vh
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
// Conversion lengths in converter clock cycles
`define ADCC_NORMAL_CYCLES 5'd13
`define ADCC_FIRST_CYCLES 5'd25
// Result width and left-adjust shift
`define ADCC_RES_W 10
`define ADCC_LEFT_SHIFT 6
// Trigger-select code of the converter's own completion flag
`define ADCC_TRIG_SELF 3'h0
// Prescaler select reset value
`define ADCC_PRESC_RST 3'h0
// Reference select codes
`define ADCC_REF_PIN 2'h0
`define ADCC_REF_SUPPLY 2'h1
`define ADCC_REF_1V1 2'h2
`define ADCC_REF_2V56 2'h3
// Channel/gain select reset value
`define ADCC_CHAN_RST 5'h00
`endif

//--- adcc_conversion_control.v
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"
module adcc_conversion_control #(
    parameter TRIG_N = 8
) (
    input wire sys_clk,
    input wire rst_b,
    input wire converterEnableBit,
    input wire startConversionWr,
    input wire autoTriggerEnable,
    input wire [2:0] triggerSourceSelect,
    input wire [TRIG_N-1:0] triggerSources,
    input wire [2:0] prescalerSelect,
    input wire leftAdjustSelect,
    input wire [4:0] channelGainSelect,
    input wire [1:0] referenceSelect,
    input wire doneFlagClearWr,
    input wire vectorTaken,
    input wire doneIrqEnable,
    input wire resultLowRd,
    input wire resultHighRd,
    input wire [`ADCC_RES_W-1:0] compCode,
    output reg startConversionBit,
    output reg conversionDoneFlag,
    output reg conversionIrq,
    output reg [7:0] resultHighByte,
    output reg [7:0] resultLowByte,
    output reg convClkEn,
    output reg sampleStart,
    output reg [4:0] appliedChannel,
    output reg [1:0] appliedReference,
    output reg [1:0] gainCode,
    output reg singleEnded,
    output reg converterPowered
);
    reg rstMeta_r;
    reg rstSync_r;
    wire rstN = rstSync_r;

    // Two-stage reset release; assertion stays asynchronous
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    reg [7:0] presc_r;
    reg [7:0] presc_nxt;
    reg busy_r;
    reg firstConv_r;
    reg [4:0] cycCnt_r;
    reg pendSw_r;
    reg trigPrev_r;
    reg blocked_r;
    wire trigSel = triggerSources[triggerSourceSelect];
    // Edge only: a source flag left set never retriggers until cleared
    wire trigEdge = autoTriggerEnable && trigSel && !trigPrev_r;
    wire selfTrig = autoTriggerEnable && (triggerSourceSelect == `ADCC_TRIG_SELF);
    wire [4:0] convLen = firstConv_r ? `ADCC_FIRST_CYCLES : `ADCC_NORMAL_CYCLES;
    reg tick;

    // Divider tap select: 2,2,4,8,16,32,64,128
    always @* begin
        presc_nxt = presc_r + 8'h01;
        case (prescalerSelect)
            3'h0: tick = presc_r[0];
            3'h1: tick = presc_r[0];
            3'h2: tick = &presc_r[1:0];
            3'h3: tick = &presc_r[2:0];
            3'h4: tick = &presc_r[3:0];
            3'h5: tick = &presc_r[4:0];
            3'h6: tick = &presc_r[5:0];
            default: tick = &presc_r[6:0];
        endcase
    end

    wire doneNow = busy_r && tick && (cycCnt_r == convLen - 5'd1);
    wire [`ADCC_RES_W-1:0] code = compCode;
    wire [15:0] leftWord = {code, 6'h00};
    wire [15:0] rightWord = {6'h00, code};
    wire [15:0] resWord = leftAdjustSelect ? leftWord : rightWord;

    // Conversion sequencer, prescaler and start logic
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            presc_r <= 8'h00;
            busy_r <= 1'b0;
            firstConv_r <= 1'b1;
            cycCnt_r <= 5'h00;
            pendSw_r <= 1'b0;
            trigPrev_r <= 1'b0;
            startConversionBit <= 1'b0;
            sampleStart <= 1'b0;
            convClkEn <= 1'b0;
        end else begin
            trigPrev_r <= trigSel;
            sampleStart <= 1'b0;
            convClkEn <= converterEnableBit && tick;
            if (!converterEnableBit) begin
                presc_r <= 8'h00;
                busy_r <= 1'b0;
                firstConv_r <= 1'b1;
                pendSw_r <= 1'b0;
                startConversionBit <= 1'b0;
            end else if (trigEdge && !busy_r && !pendSw_r) begin
                presc_r <= 8'h00;
                busy_r <= 1'b1;
                cycCnt_r <= 5'h00;
                startConversionBit <= 1'b1;
                sampleStart <= 1'b1;
            end else begin
                presc_r <= presc_nxt;
                if (startConversionWr && !busy_r) begin
                    pendSw_r <= 1'b1;
                    startConversionBit <= 1'b1;
                end
                if (pendSw_r && tick) begin
                    pendSw_r <= 1'b0;
                    busy_r <= 1'b1;
                    cycCnt_r <= 5'h00;
                    sampleStart <= 1'b1;
                end else if (doneNow) begin
                    firstConv_r <= 1'b0;
                    cycCnt_r <= 5'h00;
                    if (selfTrig) begin
                        sampleStart <= 1'b1;
                    end else begin
                        busy_r <= 1'b0;
                        startConversionBit <= 1'b0;
                    end
                end else if (busy_r && tick) begin
                    cycCnt_r <= cycCnt_r + 5'd1;
                end
            end
        end
    end

    // Result bytes with low-then-high read lock
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            blocked_r <= 1'b0;
            resultHighByte <= 8'h00;
            resultLowByte <= 8'h00;
        end else begin
            if (doneNow && !blocked_r) begin
                resultHighByte <= resWord[15:8];
                resultLowByte <= resWord[7:0];
            end // Discarded when blocked
            if (resultHighRd) begin
                blocked_r <= 1'b0;
            end else if (resultLowRd) begin
                blocked_r <= 1'b1;
            end
        end
    end

    // Completion flag: set wins over clear
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            conversionDoneFlag <= 1'b0;
            conversionIrq <= 1'b0;
        end else begin
            if (doneNow) begin
                conversionDoneFlag <= 1'b1;
            end else if (doneFlagClearWr || vectorTaken) begin
                conversionDoneFlag <= 1'b0;
            end
            // Follows the flag's next value, so a clear drops it at once unless a completion comes in the same cycle
            conversionIrq <= doneIrqEnable && (doneNow
                || (conversionDoneFlag && !doneFlagClearWr && !vectorTaken));
        end
    end

    // Selections applied only when enabled and idle or on completion
    always @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            appliedChannel <= `ADCC_CHAN_RST;
            appliedReference <= `ADCC_REF_PIN;
            gainCode <= 2'h0;
            singleEnded <= 1'b1;
            converterPowered <= 1'b0;
        end else begin
            converterPowered <= converterEnableBit;
            if (converterEnableBit && (!busy_r || doneNow)) begin
                appliedChannel <= channelGainSelect;
                appliedReference <= referenceSelect;
                singleEnded <= (channelGainSelect[4:3] == 2'b00)
                    || (channelGainSelect[4:1] == 4'hF);
                // Gain: 08, 0A, 0C, 0E use amplified pairs, others unity
                case (channelGainSelect)
                    5'h08, 5'h0C: gainCode <= 2'h1; // 10x
                    5'h0A, 5'h0E: gainCode <= 2'h2; // 200x
                    default: gainCode <= 2'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- adcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic converterEnableBit,
    input wire logic startConversionWr,
    input wire logic autoTriggerEnable,
    input wire logic doneFlagClearWr,
    input wire logic vectorTaken,
    input wire logic resultLowRd,
    input wire logic resultHighRd,
    input wire logic startConversionBit,
    input wire logic conversionDoneFlag,
    input wire logic conversionIrq,
    input wire logic [7:0] resultHighByte,
    input wire logic [7:0] resultLowByte,
    input wire logic convClkEn,
    input wire logic sampleStart,
    input wire logic [4:0] appliedChannel
);
    logic lock_r;
    // Mirror of the read lock, so a completion in the lock window is judged
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lock_r <= 1'b0;
        else if (resultHighRd) lock_r <= 1'b0;
        else if (resultLowRd) lock_r <= 1'b1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    start_taken_a: assert property (startConversionWr && converterEnableBit && !startConversionBit
        |=> ##[0:1] startConversionBit) else $error("start bit not raised");
    busy_fall_a: assert property ($fell(startConversionBit) |-> conversionDoneFlag)
        else $error("start bit fell without completion");
    single_clear_a: assert property ($rose(conversionDoneFlag) && !autoTriggerEnable
        |-> !startConversionBit) else $error("start bit still set at completion");
    irq_cause_a: assert property (conversionIrq |-> conversionDoneFlag)
        else $error("irq without flag");
    flag_clear_a: assert property ((doneFlagClearWr || vectorTaken) && !startConversionBit
        |=> !conversionDoneFlag) else $error("flag not cleared");
    result_lock_a: assert property (lock_r && $past(lock_r)
        |-> $stable({resultHighByte, resultLowByte}))
        else $error("result changed while locked");
    start_gap_a: assert property (sampleStart |=> !sampleStart [*8])
        else $error("starts too close");
    off_quiet_a: assert property (!converterEnableBit [*3] |-> !convClkEn && !sampleStart)
        else $error("converter active while disabled");
    chan_hold_a: assert property (sampleStart |=> $stable(appliedChannel) [*4])
        else $error("channel moved during conversion");
    cover property ($rose(conversionDoneFlag) && lock_r);
    cover property (sampleStart && autoTriggerEnable);
    cover property ($fell(startConversionBit));
endmodule
bind adcc_conversion_control adcc_checker chk_i (.*);
`default_nettype wire

//--- adcc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_conversion_control_tb;
    logic sys_clk = 0, rst_b = 0, en = 0, ate = 0, lad = 0;
    logic [4:0] pls = 0; // start, clear, low read, high read, vector
    logic [2:0] tsel = 0;
    logic [7:0] trg = 0;
    logic [4:0] chan = 0;
    logic [9:0] code = 0;
    logic [15:0] old;
    wire busy, flag, irq, sst;
    wire [7:0] hi, lo;
    wire [4:0] appliedChannel;
    wire [1:0] refSel, gain;
    wire se, pwr;
    integer seed = 7, error_cnt = 0, n_compared = 0, nStart = 0, i, k, s0;
    adcc_conversion_control DUT (.sys_clk(sys_clk), .rst_b(rst_b), .converterEnableBit(en),
        .startConversionWr(pls[0]), .autoTriggerEnable(ate), .triggerSourceSelect(tsel),
        .triggerSources({trg[7:1], flag}), .prescalerSelect(3'h0), .leftAdjustSelect(lad),
        .channelGainSelect(chan), .referenceSelect(2'h1), .doneFlagClearWr(pls[1]),
        .vectorTaken(pls[4]), .doneIrqEnable(1'b1), .resultLowRd(pls[2]),
        .resultHighRd(pls[3]), .compCode(code), .startConversionBit(busy),
        .conversionDoneFlag(flag), .conversionIrq(irq), .resultHighByte(hi),
        .resultLowByte(lo), .convClkEn(), .sampleStart(sst), .appliedChannel(appliedChannel),
        .appliedReference(refSel), .gainCode(gain), .singleEnded(se),
        .converterPowered(pwr));
    initial forever #2 sys_clk = ~sys_clk;
    // Counts conversion starts; restarts show up here even when busy hides them
    always @(posedge sys_clk) if (sst === 1'b1) nStart <= nStart + 1;
    function [15:0] fmt(input l, input [9:0] c);
        fmt = l ? {c, 6'h0} : {6'h0, c};
    endfunction
    task chk(input string nm, input [15:0] s, input [15:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task pulse(input [4:0] p);
        pls = p;
        @(negedge sys_clk) pls = 0;
        @(negedge sys_clk);
    endtask
    // Bounded wait for completion, then clear through the given path
    task wait_flag(input [4:0] clr);
        for (i = 0; i < 200 && flag !== 1'b1; i++) @(negedge sys_clk);
        chk("flag", flag, 1);
        chk("irq", irq, 1);
        pulse(clr);
        chk("flag clr", flag, 0);
    endtask
    task conv(input l, input [9:0] c);
        lad = l;
        code = c;
        pulse(5'h01);
        @(negedge sys_clk) chk("busy", busy, 1);
        wait_flag(k[0] ? 5'h10 : 5'h02);
        chk("idle", busy, 0);
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        chan = 5'(1 + {$random(seed)} % 7);
        repeat (2) @(negedge sys_clk);
        rst_b = 1;
        repeat (4) @(negedge sys_clk);
        chk("chan off", appliedChannel, 0);
        en = 1;
        repeat (4) @(negedge sys_clk);
        chk("chan on", appliedChannel, chan);
        chk("single", se, 1);
        chk("gain", gain, 0);
        chk("ref", refSel, 1);
        // Extremes of the code first, then random codes, both alignments
        for (k = 0; k < 6; k++) begin
            conv(k[0], k < 2 ? {10{k[0]}} : 10'($random(seed)));
            chk("result", {hi, lo}, fmt(k[0], code));
        end
        $display("end single");
        old = fmt(lad, code);
        pulse(5'h04);
        conv(0, ~code);
        chk("locked", {hi, lo}, old);
        pulse(5'h08);
        conv(0, code);
        chk("unlocked", {hi, lo}, fmt(0, code));
        $display("end lock");
        ate = 1;
        tsel = 3'h3;
        s0 = nStart;
        trg[5] = 1;
        repeat (8) @(negedge sys_clk);
        chk("other source", nStart - s0, 0);
        trg[3] = 1;
        repeat (8) @(negedge sys_clk);
        chk("auto", busy, 1);
        trg[3] = 0;
        @(negedge sys_clk) trg[3] = 1;
        wait_flag(5'h02);
        chk("auto result", {hi, lo}, fmt(0, code));
        repeat (80) @(negedge sys_clk);
        chk("no restart", nStart - s0, 1);
        conv(1, 10'($random(seed)));
        chk("sw start", {hi, lo}, fmt(1, code));
        $display("end auto");
        tsel = 3'h0;
        pulse(5'h01);
        s0 = nStart;
        repeat (150) @(negedge sys_clk);
        chk("free run", nStart - s0 >= 4, 1);
        chk("free busy", busy, 1);
        $display("end free run");
        en = 0;
        repeat (4) @(negedge sys_clk);
        chk("power", pwr, 0);
        chk("off idle", busy, 0);
        chan = 5'h0A;
        en = 1;
        repeat (4) @(negedge sys_clk);
        chk("diff gain", gain, 2);
        chk("diff pair", se, 0);
        $display("end power");
        test_done;
    end
    initial begin
        #20000;
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire
